// >>> design/sns_cfg.svh
// Purpose: constants of the sensor configuration register bank
// Assumes: byte-wide registers at byte offsets
// Notes:   addresses, field positions, reset values, timing
`ifndef SNS_CFG_SVH
`define SNS_CFG_SVH
// register offsets
`define SNS_A_INTST  8'h11
`define SNS_A_SRC    8'h18
`define SNS_A_IRQ    8'h19
`define SNS_A_IFC    8'h1A
`define SNS_A_PWR    8'h1B
`define SNS_A_OSR    8'h1C
`define SNS_A_ODR    8'h1D
// defined bits of each writable register
`define SNS_M_SRC    8'h1F
`define SNS_M_IRQ    8'h5F
`define SNS_M_IFC    8'h07
`define SNS_M_PWR    8'h33
`define SNS_M_OSR    8'h3F
`define SNS_M_ODR    8'h1F
// reset values
`define SNS_RST_SRC  8'h00
`define SNS_RST_IRQ  8'h00
`define SNS_RST_IFC  8'h00
`define SNS_RST_PWR  8'h00
`define SNS_RST_OSR  8'h00
`define SNS_RST_ODR  8'h00
// field positions
`define SNS_F_DECIM  2:0
`define SNS_F_SRC    4:3
`define SNS_B_OD     0
`define SNS_B_LVL    1
`define SNS_B_LATCH  2
`define SNS_B_FWM    3
`define SNS_B_FFULL  4
`define SNS_B_DRDY   6
`define SNS_B_3W     0
`define SNS_B_WDTEN  1
`define SNS_B_WDTSEL 2
`define SNS_B_PEN    0
`define SNS_B_TEN    1
`define SNS_F_MODE   5:4
`define SNS_F_OSRP   2:0
`define SNS_F_OSRT   5:3
`define SNS_F_ODR    4:0
`define SNS_S_FWM    0
`define SNS_S_FFULL  1
`define SNS_S_DRDY   3
// field codes and limits
`define SNS_SRC_FILT 2'h1
`define SNS_MODE_SLP 2'h0
`define SNS_MODE_NRM 2'h3
`define SNS_OSR_MAX  3'h5
`define SNS_ODR_MAX  5'h11
// timing
`define SNS_CLK_NS       4
`define SNS_WDT_SHORT_US 1250
`define SNS_WDT_LONG_US  40000
`endif

// >>> design/sns_pkg.sv
// Purpose: types of the sensor configuration register bank
// Assumes: nothing
// Notes:   constants live in sns_cfg.svh
package sns_pkg;
   typedef enum logic [1:0] {
      SNS_SLEEP,
      SNS_FORCED,
      SNS_NORMAL
   } sns_pwr_mode_t;
   typedef enum logic [1:0] {
      SNS_WDT_IDLE,
      SNS_WDT_RUN,
      SNS_WDT_TRIP
   } sns_wdt_st_t;
endpackage

// >>> design/sns_irq.sv
// Purpose: interrupt flags and interrupt pin driver
// Assumes: events synchronous to sys_clk
// Notes:   pin and flags update together
`timescale 1ns/1ns
module sns_irq (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] ev,
   input  wire logic [2:0] ev_en,
   input  wire logic       latch,
   input  wire logic       clr,
   input  wire logic       drive_od,
   input  wire logic       act_high,
   output logic      [2:0] flags,
   output logic            pin_o,
   output logic            pin_oe
);
   import sns_pkg::*;
   logic [2:0] flags_nxt;
   logic       pin_nxt;
   logic       oe_nxt;
   logic       lvl;

   // gated events, sticky when latching, set beats clear
   always_comb begin
      flags_nxt = ev & ev_en;
      if (latch) begin
         flags_nxt = (flags & ~{3{clr}}) | (ev & ev_en);
      end
      lvl = act_high ? (|flags_nxt) : ~(|flags_nxt);
      pin_nxt = drive_od ? 1'b0 : lvl;
      oe_nxt = drive_od ? ~lvl : 1'b1;
   end

   // flag and pin registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags  <= 3'h0;
         pin_o  <= 1'b1;
         pin_oe <= 1'b1;
      end else begin
         flags  <= flags_nxt;
         pin_o  <= pin_nxt;
         pin_oe <= oe_nxt;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_pin_push: assert property (!drive_od |=> pin_oe)
      else $error("push-pull pin not driven");
   a_pin_level: assert property ((!drive_od && act_high) |=>
      (pin_o == (|flags))) else $error("pin level wrong");
   a_latch_hold: assert property ((latch && flags[0] && !clr)
      |=> flags[0]) else $error("latched flag lost");
   a_gate_fwm: assert property ((!ev_en[0] && clr)
      |=> !flags[0]) else $error("watermark flag not gated");
   a_gate_full: assert property ((!ev_en[1] && clr)
      |=> !flags[1]) else $error("full flag not gated");
   a_gate_drdy: assert property ((!ev_en[2] && clr)
      |=> !flags[2]) else $error("ready flag not gated");
   c_latched_irq: cover property (latch && flags[2] && clr);
endmodule // sns_irq

// >>> design/sns_wdt.sv
// Purpose: bus watchdog for stalled serial transactions
// Assumes: bus_edge pulses on each bus clock edge
// Notes:   abort is a one-cycle pulse
`timescale 1ns/1ns
module sns_wdt #(
   parameter int SHORT_CYC = 312500,
   parameter int LONG_CYC  = 10000000
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic enable,
   input  wire logic long_sel,
   input  wire logic bus_active,
   input  wire logic bus_edge,
   output logic      abort
);
   import sns_pkg::*;
   sns_wdt_st_t st_r, st_nxt;
   logic [23:0] cnt_r, cnt_nxt, lim;
   logic        abort_nxt;

   // stall counter, restarted by every bus edge
   always_comb begin
      lim = long_sel ? LONG_CYC[23:0] : SHORT_CYC[23:0];
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      abort_nxt = 1'b0;
      case (st_r)
         SNS_WDT_IDLE: begin
            cnt_nxt = 24'h0;
            if (enable && bus_active) st_nxt = SNS_WDT_RUN;
         end
         SNS_WDT_RUN: begin
            if (!enable || !bus_active) begin
               st_nxt = SNS_WDT_IDLE;
            end else if (bus_edge) begin
               cnt_nxt = 24'h0;
            end else if (cnt_r >= lim - 24'h1) begin // period cut mid-count
               st_nxt = SNS_WDT_TRIP;
               abort_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 24'h1;
            end
         end
         SNS_WDT_TRIP: begin
            if (!bus_active) st_nxt = SNS_WDT_IDLE;
         end
         default: st_nxt = SNS_WDT_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r  <= SNS_WDT_IDLE;
         cnt_r <= 24'h0;
         abort <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         abort <= abort_nxt;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_wdt_abort: assert property ((st_r == SNS_WDT_RUN && enable &&
      bus_active && !bus_edge && cnt_r == lim - 24'h1) |=> abort)
      else $error("watchdog did not abort");
   a_wdt_once: assert property (abort |=> !abort)
      else $error("abort longer than one cycle");
   a_wdt_off: assert property (!enable |=> !abort)
      else $error("abort while watchdog disabled");
   c_wdt_abort: cover property (abort);
endmodule // sns_wdt

// >>> design/sns_cfg_bank.sv
// Purpose: configuration register bank of a pressure sensor
// Assumes: register port driven by the serial protocol engine
// Notes:   read data valid one cycle after reg_rd
`timescale 1ns/1ns
`include "sns_cfg.svh"
module sns_cfg_bank #(
   parameter int WDT_SHORT_CYC =
      `SNS_WDT_SHORT_US * 1000 / `SNS_CLK_NS,
   parameter int WDT_LONG_CYC =
      `SNS_WDT_LONG_US * 1000 / `SNS_CLK_NS
) (
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   input  wire logic          soft_reset,
   input  wire logic          nvm_wdt_en,
   input  wire logic          nvm_wdt_sel,
   input  wire logic [7:0]    reg_addr,
   input  wire logic          reg_wr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_rd,
   output logic      [7:0]    reg_rdata,
   input  wire logic          sample_in,
   output logic               sample_keep,
   output logic               use_filtered,
   input  wire logic          ev_fwm,
   input  wire logic          ev_ffull,
   input  wire logic          ev_drdy,
   output logic               int_pin_o,
   output logic               int_pin_oe,
   output logic               three_wire_serial,
   input  wire logic          i2c_active,
   input  wire logic          i2c_edge,
   output logic               i2c_abort,
   input  wire logic          meas_tick,
   output logic               meas_start_press,
   output logic               meas_start_temp,
   output sns_pkg::sns_pwr_mode_t pwr_mode,
   output logic      [5:0]    press_osr_ratio,
   output logic      [5:0]    temperature_oversample,
   output logic      [4:0]    rate_div_exp
);
   import sns_pkg::*;
   logic [7:0]  src_r, irq_r, ifc_r, pwr_r, osr_r, odr_r;
   logic [7:0]  src_nxt, irq_nxt, ifc_nxt, pwr_nxt, osr_nxt;
   logic [7:0]  odr_nxt, rd_nxt, intst;
   logic        nvm_done_r, nvm_done_nxt;
   logic [6:0]  dec_cnt_r, dec_cnt_nxt;
   logic [7:0]  dec_mask;
   logic [16:0] rate_cnt_r, rate_cnt_nxt;
   logic [17:0] rate_mask;
   logic        force_r, force_nxt, fire;
   logic        keep_nxt, filt_nxt, sp_nxt, st_nxt;
   logic [4:0]  exp_sat;
   logic [2:0]  flags;
   logic        st_rd;
   sns_pwr_mode_t mode_nxt;

   // oversampling code to one-hot ratio, undefined codes at x32
   function automatic logic [5:0] osr_ratio(input logic [2:0] c);
      logic [2:0] s;
      s = (c > `SNS_OSR_MAX) ? `SNS_OSR_MAX : c;
      osr_ratio = 6'h01 << s;
   endfunction

   // status read strobe clears the flags
   assign st_rd = reg_rd && (reg_addr == `SNS_A_INTST);

   // register writes, soft reset and nonvolatile defaults
   always_comb begin
      src_nxt = src_r;
      irq_nxt = irq_r;
      ifc_nxt = ifc_r;
      pwr_nxt = pwr_r;
      osr_nxt = osr_r;
      odr_nxt = odr_r;
      nvm_done_nxt = 1'b1;
      force_nxt = 1'b0;
      if (soft_reset) begin
         src_nxt = `SNS_RST_SRC;
         irq_nxt = `SNS_RST_IRQ;
         ifc_nxt = `SNS_RST_IFC;
         pwr_nxt = `SNS_RST_PWR;
         osr_nxt = `SNS_RST_OSR;
         odr_nxt = `SNS_RST_ODR;
         nvm_done_nxt = 1'b0;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `SNS_A_SRC: src_nxt = reg_wdata & `SNS_M_SRC;
               `SNS_A_IRQ: irq_nxt = reg_wdata & `SNS_M_IRQ;
               `SNS_A_IFC: ifc_nxt = reg_wdata & `SNS_M_IFC;
               `SNS_A_PWR: begin
                  pwr_nxt = reg_wdata & `SNS_M_PWR;
                  force_nxt = (reg_wdata[`SNS_F_MODE] !=
                     `SNS_MODE_SLP) && (reg_wdata[`SNS_F_MODE] !=
                     `SNS_MODE_NRM);
               end
               `SNS_A_OSR: osr_nxt = reg_wdata & `SNS_M_OSR;
               `SNS_A_ODR: odr_nxt = reg_wdata & `SNS_M_ODR;
               default: src_nxt = src_r;
            endcase
         end
         if (!nvm_done_r) begin
            ifc_nxt[`SNS_B_WDTEN] = nvm_wdt_en;
            ifc_nxt[`SNS_B_WDTSEL] = nvm_wdt_sel;
         end
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         src_r <= `SNS_RST_SRC;
         irq_r <= `SNS_RST_IRQ;
         ifc_r <= `SNS_RST_IFC;
         pwr_r <= `SNS_RST_PWR;
         osr_r <= `SNS_RST_OSR;
         odr_r <= `SNS_RST_ODR;
         nvm_done_r <= 1'b0;
         force_r <= 1'b0;
      end else begin
         src_r <= src_nxt;
         irq_r <= irq_nxt;
         ifc_r <= ifc_nxt;
         pwr_r <= pwr_nxt;
         osr_r <= osr_nxt;
         odr_r <= odr_nxt;
         nvm_done_r <= nvm_done_nxt;
         force_r <= force_nxt;
      end
   end

   // status image and read data mux
   always_comb begin
      intst = 8'h00;
      intst[`SNS_S_FWM] = flags[0];
      intst[`SNS_S_FFULL] = flags[1];
      intst[`SNS_S_DRDY] = flags[2];
      rd_nxt = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            `SNS_A_INTST: rd_nxt = intst;
            `SNS_A_SRC: rd_nxt = src_r;
            `SNS_A_IRQ: rd_nxt = irq_r;
            `SNS_A_IFC: rd_nxt = ifc_r;
            `SNS_A_PWR: rd_nxt = pwr_r;
            `SNS_A_OSR: rd_nxt = osr_r;
            `SNS_A_ODR: rd_nxt = odr_r;
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   // decimation, rate divider and measurement triggers
   always_comb begin
      dec_mask = (8'h01 << src_r[`SNS_F_DECIM]) - 8'h01;
      dec_cnt_nxt = dec_cnt_r;
      keep_nxt = 1'b0;
      if (sample_in) begin
         keep_nxt = ((dec_cnt_r & dec_mask[6:0]) == 7'h00);
         dec_cnt_nxt = dec_cnt_r + 7'h01;
      end
      filt_nxt = (src_r[`SNS_F_SRC] == `SNS_SRC_FILT);
      exp_sat = (odr_r[`SNS_F_ODR] > `SNS_ODR_MAX) ?
         `SNS_ODR_MAX : odr_r[`SNS_F_ODR];
      rate_mask = (18'h00001 << exp_sat) - 18'h00001;
      rate_cnt_nxt = rate_cnt_r;
      fire = force_r;
      if (pwr_r[`SNS_F_MODE] == `SNS_MODE_NRM && meas_tick) begin
         fire = ((rate_cnt_r & rate_mask[16:0]) == 17'h0);
         rate_cnt_nxt = rate_cnt_r + 17'h1;
      end
      sp_nxt = fire && pwr_r[`SNS_B_PEN];
      st_nxt = fire && pwr_r[`SNS_B_TEN];
      case (pwr_r[`SNS_F_MODE])
         `SNS_MODE_SLP: mode_nxt = SNS_SLEEP;
         `SNS_MODE_NRM: mode_nxt = SNS_NORMAL;
         default: mode_nxt = SNS_FORCED;
      endcase
   end

   // registered outputs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         dec_cnt_r <= 7'h00;
         rate_cnt_r <= 17'h0;
         sample_keep <= 1'b0;
         use_filtered <= 1'b0;
         meas_start_press <= 1'b0;
         meas_start_temp <= 1'b0;
         pwr_mode <= SNS_SLEEP;
         three_wire_serial <= 1'b0;
         press_osr_ratio <= 6'h01;
         temperature_oversample <= 6'h01;
         rate_div_exp <= 5'h00;
      end else begin
         reg_rdata <= rd_nxt;
         dec_cnt_r <= dec_cnt_nxt;
         rate_cnt_r <= rate_cnt_nxt;
         sample_keep <= keep_nxt;
         use_filtered <= filt_nxt;
         meas_start_press <= sp_nxt;
         meas_start_temp <= st_nxt;
         pwr_mode <= mode_nxt;
         three_wire_serial <= ifc_r[`SNS_B_3W];
         press_osr_ratio <= osr_ratio(osr_r[`SNS_F_OSRP]);
         temperature_oversample <= osr_ratio(osr_r[`SNS_F_OSRT]);
         rate_div_exp <= exp_sat;
      end
   end

   // interrupt flags and pin
   sns_irq u_irq (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .ev       ({ev_drdy, ev_ffull, ev_fwm}),
      .ev_en    ({irq_r[`SNS_B_DRDY], irq_r[`SNS_B_FFULL],
                  irq_r[`SNS_B_FWM]}),
      .latch    (irq_r[`SNS_B_LATCH]),
      .clr      (st_rd),
      .drive_od (irq_r[`SNS_B_OD]),
      .act_high (irq_r[`SNS_B_LVL]),
      .flags    (flags),
      .pin_o    (int_pin_o),
      .pin_oe   (int_pin_oe)
   );

   // bus watchdog
   sns_wdt #(
      .SHORT_CYC (WDT_SHORT_CYC),
      .LONG_CYC  (WDT_LONG_CYC)
   ) u_wdt (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .enable     (ifc_r[`SNS_B_WDTEN]),
      .long_sel   (ifc_r[`SNS_B_WDTSEL]),
      .bus_active (i2c_active),
      .bus_edge   (i2c_edge),
      .abort      (i2c_abort)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_decim_pass: assert property ((sample_in &&
      src_r[`SNS_F_DECIM] == 3'h0) |=> sample_keep)
      else $error("sample dropped without decimation");
   a_decim_skip: assert property ((src_r[`SNS_F_DECIM] != 3'h0 &&
      $stable(src_r)) throughout ((sample_keep && !sample_in) ##1 sample_in)
      |=> !sample_keep) else $error("decimation not applied");
   a_src_filt: assert property (use_filtered |->
      $past(src_r[`SNS_F_SRC]) == `SNS_SRC_FILT)
      else $error("filtered source for wrong code");
   a_three_wire: assert property ((reg_wr && !soft_reset &&
      reg_addr == `SNS_A_IFC) |=> ##1 three_wire_serial ==
      $past(reg_wdata[`SNS_B_3W], 2)) else $error("wire mode wrong");
   a_nvm_load: assert property ($rose(nvm_done_r) |->
      ifc_r[`SNS_B_WDTEN] == $past(nvm_wdt_en))
      else $error("watchdog default not loaded");
   a_meas_gate: assert property (meas_start_press |->
      $past(pwr_r[`SNS_B_PEN])) else $error("pressure not enabled");
   a_sleep_quiet: assert property (($past(pwr_r[`SNS_F_MODE]) ==
      `SNS_MODE_SLP && !$past(force_r)) |-> !meas_start_temp)
      else $error("measurement in sleep");
   a_osr_onehot: assert property ($onehot(press_osr_ratio))
      else $error("oversampling ratio not one-hot");
   a_odr_sat: assert property (rate_div_exp <= `SNS_ODR_MAX)
      else $error("rate exponent above limit");
   a_rd_clear: assert property ((st_rd && !ev_fwm && !ev_ffull &&
      !ev_drdy) |=> flags == 3'h0) else $error("flags not cleared");
   a_rsvd_zero: assert property ((reg_rd && reg_addr == `SNS_A_OSR)
      |=> reg_rdata[7:6] == 2'h0) else $error("reserved bits set");
   c_forced: cover property (force_r ##1 meas_start_press);
   c_normal: cover property (pwr_mode == SNS_NORMAL ##1 meas_start_temp);
   c_decim: cover property (sample_in && src_r[`SNS_F_DECIM] == 3'h3);
endmodule // sns_cfg_bank

// >>> test/sns_host_model.sv
// Purpose: host controller model driving the register port
// Assumes: single byte accesses, one at a time
// Notes:   released address and data lines carry the inverted last value
`timescale 1ns/1ns
module sns_host_model (
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // idle port at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end
   // one byte write, taken at the following edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk) #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge sys_clk) #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;  // released lines do not keep the value
      reg_wdata = ~d;
   endtask
   // one byte read, data settled one cycle after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk) #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge sys_clk) #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask
endmodule // sns_host_model

// >>> test/test_sensor_config_register_bank.sv
// Purpose: self-checking bench of the sensor configuration register bank
// Assumes: host model drives the register port, bench drives the rest
// Notes:   watchdog limits shortened to 20 and 50 cycles
`timescale 1ns/1ns
`include "sns_cfg.svh"
module test_sensor_config_register_bank;
   import sns_pkg::*;
   localparam int WS = 20;
   localparam int WL = 50;
   logic           sys_clk = 1'b0;
   logic           reset_n = 1'b0;
   logic           nvm_wdt_en = 1'b1;
   logic           nvm_wdt_sel = 1'b0;
   logic           soft_reset = 1'b0;
   logic           sample_in = 1'b0;
   logic           ev_fwm = 1'b0;
   logic           ev_ffull = 1'b0;
   logic           ev_drdy = 1'b0;
   logic           i2c_active = 1'b0;
   logic           i2c_edge = 1'b0;
   logic           meas_tick = 1'b0;
   logic     [7:0] reg_addr, reg_wdata, reg_rdata;
   logic           reg_wr, reg_rd, sample_keep, use_filtered;
   logic           int_pin_o, int_pin_oe, three_wire_serial, i2c_abort;
   logic           meas_start_press, meas_start_temp;
   sns_pwr_mode_t  pwr_mode;
   logic     [5:0] press_osr_ratio, temperature_oversample;
   logic     [4:0] rate_div_exp;
   int             err_count = 0;
   int             total_checks = 0;
   int             cycles = 0;

   sns_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   sns_cfg_bank #(.WDT_SHORT_CYC(WS), .WDT_LONG_CYC(WL)) i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .soft_reset(soft_reset),
      .nvm_wdt_en(nvm_wdt_en), .nvm_wdt_sel(nvm_wdt_sel),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in),
      .sample_keep(sample_keep), .use_filtered(use_filtered),
      .ev_fwm(ev_fwm), .ev_ffull(ev_ffull), .ev_drdy(ev_drdy),
      .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
      .three_wire_serial(three_wire_serial), .i2c_active(i2c_active),
      .i2c_edge(i2c_edge), .i2c_abort(i2c_abort), .meas_tick(meas_tick),
      .meas_start_press(meas_start_press),
      .meas_start_temp(meas_start_temp), .pwr_mode(pwr_mode),
      .press_osr_ratio(press_osr_ratio),
      .temperature_oversample(temperature_oversample),
      .rate_div_exp(rate_div_exp));

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      chk(d, e);
   endtask

   // reset values, masked read-back and an unmapped place
   task automatic t_regs();
      logic [7:0] a [6] = '{`SNS_A_SRC, `SNS_A_IRQ, `SNS_A_IFC,
                            `SNS_A_PWR, `SNS_A_OSR, `SNS_A_ODR};
      logic [7:0] m [6] = '{`SNS_M_SRC, `SNS_M_IRQ, `SNS_M_IFC,
                            `SNS_M_PWR, `SNS_M_OSR, `SNS_M_ODR};
      for (int i = 0; i < 6; i++) begin
         rchk(a[i], (i == 2) ? 8'h02 : 8'h00);
         i_host.wr(a[i], 8'hFF);
         rchk(a[i], m[i]);
      end
      i_host.wr(8'h20, 8'hFF);
      rchk(8'h20, 8'h00);
      for (int i = 0; i < 6; i++) i_host.wr(a[i], 8'h00);
   endtask

   // oversampling codes and divider saturation
   task automatic t_rates();
      logic [7:0] v [4] = '{8'h00, 8'h11, 8'h12, 8'h1F};
      for (int k = 0; k < 6; k++) begin
         i_host.wr(`SNS_A_OSR, {2'b00, 3'(k), 3'(5 - k)});
         cyc(1);
         chk({2'b00, press_osr_ratio}, 8'(1 << (5 - k)));
         chk({2'b00, temperature_oversample}, 8'(1 << k));
      end
      for (int i = 0; i < 4; i++) begin
         i_host.wr(`SNS_A_ODR, v[i]);
         cyc(1);
         chk({3'b000, rate_div_exp}, (i == 0) ? 8'h00 : 8'h11);
      end
   endtask

   // latched and live interrupt flags, pin drive and polarity
   task automatic t_irq();
      i_host.wr(`SNS_A_IRQ, 8'h5C);
      ev_fwm   = 1'b1;
      ev_ffull = 1'b1;
      cyc(1);
      ev_fwm   = 1'b0;
      ev_ffull = 1'b0;
      chk({int_pin_oe, int_pin_o}, 8'h02);
      cyc(3);
      chk({int_pin_oe, int_pin_o}, 8'h02);
      rchk(`SNS_A_INTST, 8'h03);
      cyc(1);
      chk({int_pin_oe, int_pin_o}, 8'h03);
      rchk(`SNS_A_INTST, 8'h00);
      i_host.wr(`SNS_A_IRQ, 8'h4B);
      ev_ffull = 1'b1;
      cyc(2);
      chk({int_pin_oe, int_pin_o}, 8'h02);
      ev_ffull = 1'b0;
      ev_drdy  = 1'b1;
      cyc(2);
      chk({7'h00, int_pin_oe}, 8'h00);
      rchk(`SNS_A_INTST, 8'h08);
      ev_drdy  = 1'b0;
      cyc(2);
      chk({int_pin_oe, int_pin_o}, 8'h02);
      i_host.wr(`SNS_A_IRQ, 8'h42);
      ev_drdy  = 1'b1;
      cyc(2);
      chk({int_pin_oe, int_pin_o}, 8'h03);
      rchk(`SNS_A_INTST, 8'h08);
      ev_drdy  = 1'b0;
   endtask

   // forced, normal and sleep modes with channel enables
   task automatic t_meas();
      logic [7:0] np, nt;
      i_host.wr(`SNS_A_PWR, 8'h11);
      cyc(1);
      chk({6'h00, pwr_mode}, {6'h00, SNS_FORCED});
      chk({meas_start_temp, meas_start_press}, 8'h01);
      i_host.wr(`SNS_A_PWR, 8'h22);
      cyc(1);
      chk({6'h00, pwr_mode}, {6'h00, SNS_FORCED});
      chk({meas_start_temp, meas_start_press}, 8'h02);
      i_host.wr(`SNS_A_ODR, 8'h01);
      i_host.wr(`SNS_A_PWR, 8'h32);
      cyc(1);
      chk({6'h00, pwr_mode}, {6'h00, SNS_NORMAL});
      for (int s = 0; s < 2; s++) begin
         np = 8'h00;
         nt = 8'h00;
         repeat (4) begin
            meas_tick = 1'b1;
            cyc(1);
            meas_tick = 1'b0;
            np = np + meas_start_press;
            nt = nt + meas_start_temp;
            cyc(1);
         end
         chk({np[3:0], nt[3:0]}, (s == 0) ? 8'h02 : 8'h00);
         i_host.wr(`SNS_A_PWR, 8'h03);
         cyc(1);
      end
      chk({6'h00, pwr_mode}, {6'h00, SNS_SLEEP});
   endtask

   // decimation and sample source codes
   task automatic t_fifo();
      logic [7:0] n = 8'h00;
      i_host.wr(`SNS_A_SRC, 8'h02);
      repeat (8) begin
         sample_in = 1'b1;
         cyc(1);
         sample_in = 1'b0;
         n = n + sample_keep;
         cyc(1);
      end
      chk(n, 8'h02);
      for (int c = 0; c < 4; c++) begin
         i_host.wr(`SNS_A_SRC, {3'b000, 2'(c), 3'b000});
         cyc(1);
         chk({7'h00, use_filtered}, (c == 1) ? 8'h01 : 8'h00);
      end
      sample_in = 1'b1;
      cyc(1);
      sample_in = 1'b0;
      chk({7'h00, sample_keep}, 8'h01);
   endtask

   // soft reset restores defaults and reloads the nonvolatile bits
   task automatic t_soft();
      nvm_wdt_sel = 1'b1;
      soft_reset  = 1'b1;
      cyc(1);
      soft_reset  = 1'b0;
      rchk(`SNS_A_IFC, 8'h06);
   endtask

   // stalled transfer, cycles until abort (120 means none)
   task automatic wd(input logic kick, output int n);
      i2c_active = 1'b1;
      n = 0;
      while (i2c_abort !== 1'b1 && n < 120) begin
         i2c_edge = kick && (n % 10 == 9);
         cyc(1);
         n++;
      end
      i2c_edge   = 1'b0;
      i2c_active = 1'b0;
      cyc(2);
   endtask

   // watchdog periods, enable, kicks and three-wire select
   task automatic t_wdt();
      int n;
      i_host.wr(`SNS_A_IFC, 8'h03);
      cyc(1);
      chk({7'h00, three_wire_serial}, 8'h01);
      wd(1'b0, n);
      chk(8'(n >= WS - 1 && n <= WS + 3), 8'h01);
      wd(1'b1, n);
      chk(8'(n), 8'd120);
      i_host.wr(`SNS_A_IFC, 8'h06);
      cyc(1);
      chk({7'h00, three_wire_serial}, 8'h00);
      wd(1'b0, n);
      chk(8'(n >= WL - 1 && n <= WL + 3), 8'h01);
      i_host.wr(`SNS_A_IFC, 8'h04);
      wd(1'b0, n);
      chk(8'(n), 8'd120);
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      cyc(2);
      t_regs();
      t_rates();
      t_irq();
      t_meas();
      t_fifo();
      t_wdt();
      t_soft();
      finish_test();
   end
endmodule // test_sensor_config_register_bank
